// ===== ces_consts.vh
// Constants shared by the communication error supervisor files
`ifndef CES_CONSTS_VH
`define CES_CONSTS_VH

// Setting widths and special values
`define CES_SET_W            14
`define CES_SET_DISABLE      14'h270f
`define CES_RETRY_MAX        14'h000a
`define CES_RETRY_RESET      14'h0001
`define CES_LOSS_RESET       14'h0000
`define CES_MODE_RESET       2'h0
`define CES_MODE_MAX         2'h2

// Setting select codes for the write port
`define CES_SEL_RETRY        2'h0
`define CES_SEL_LOSS         2'h1
`define CES_SEL_MODE         2'h2

// Error stop modes
`define CES_MODE_COAST       2'h0
`define CES_MODE_DECEL       2'h1
`define CES_MODE_SOFT        2'h2

// Output terminal function codes for the minor alarm
`define CES_TERM_ALARM_POS   8'h62
`define CES_TERM_ALARM_NEG   8'hc6

// Loss-check step time and system clock period
`define CES_STEP_TIME_MS     100
`define CES_CLK_PERIOD_NS    10
`define CES_STEP_CYCLES      ((`CES_STEP_TIME_MS * 1000000) / `CES_CLK_PERIOD_NS)

`endif

// ===== ces_step_gen.v
// Restartable step pulse generator for the loss-check timer
`timescale 1ns/100ps
`default_nettype none

module ces_step_gen #(
  parameter CYCLES = 10000000,            // Clock cycles per step
  parameter CNT_W  = 24                   // Counter width, must hold CYCLES
) (
  input  wire             clk_sys,        // System clock
  input  wire             rst_n,          // Asynchronous reset, active low
  input  wire             restart,        // Restart the step phase
  output reg              step            // One-cycle pulse per step
);

  localparam [31:0]      LAST_FULL = CYCLES - 1;            // Terminal count, integer width
  localparam [CNT_W-1:0] LAST      = LAST_FULL[CNT_W-1:0];  // Cut to counter width on purpose

  reg [CNT_W-1:0] count;                  // Cycles into current step

  // Phase restarts on each frame so a step is never cut short
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= {CNT_W{1'b0}};
      step  <= 1'b0;
    end
    else if (restart)
    begin
      count <= {CNT_W{1'b0}};
      step  <= 1'b0;
    end
    else if (count == LAST)
    begin
      count <= {CNT_W{1'b0}};
      step  <= 1'b1;
    end
    else
    begin
      count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      step  <= 1'b0;
    end
  end

endmodule // ces_step_gen

`default_nettype wire

// ===== ces_comm_error_supervisor.v
// Communication error supervisor: retry limit, signal loss check, stop mode control
`timescale 1ns/100ps
`default_nettype none
`include "ces_consts.vh"

// Behaviour
// - Retry limit 0 to 10 or 9999, reset 1
// - Errors beyond limit trip per stop mode
// - Retry 9999: no trip, raise minor alarm
// - Alarm on terminals coded 98 or 198
// - Retry counting only under computer-link protocol
// - Loss of communication trips per stop mode
// - Interval 9999 disables loss detection
// - Interval 0 trips on entering network mode
// - Trip after silence longer than interval
// - Any received frame clears loss timer
// - Timer starts at first frame in network mode
// - Stop modes: coast, decel, decel with restart
// - Settings writable only when display select zero
// - Restart resumes previous run and speed commands
// - Mode 2 error cleared mid-decel: accelerate again at once
module ces_comm_error_supervisor #(
  parameter STEP_CYCLES = `CES_STEP_CYCLES  // Clock cycles per 0.1 s step
) (
  input  wire        clk_sys,                // System clock, 100 MHz
  input  wire        rst_n,                  // Asynchronous reset, active low
  input  wire        cfgWrite,               // Setting write strobe, one cycle
  input  wire [1:0]  cfgSelect,              // Which setting to write
  input  wire [13:0] cfgData,                // Value to write
  input  wire [13:0] extendedDisplaySelect,  // Writes allowed only when zero
  input  wire        protocolModbus,         // High while Modbus-RTU selected
  input  wire        networkRunMode,         // High while network controlled run
  input  wire        frameRx,                // Frame received, any station, pulse
  input  wire        frameRxError,           // Receive error on a frame, pulse
  input  wire        decelDone,              // Ramp generator reports motor stopped
  input  wire        faultReset,             // Clears a latched trip, pulse
  input  wire [7:0]  outputTerminalSelectA,  // Function code of terminal A
  input  wire [7:0]  outputTerminalSelectB,  // Function code of terminal B
  input  wire [7:0]  outputTerminalSelectC,  // Function code of terminal C
  output reg  [13:0] retryLimitSetting,      // Current retry limit
  output reg  [13:0] lossCheckInterval,      // Current interval, 0.1 s units
  output reg  [1:0]  errorStopMode,          // Current stop mode
  output reg         cfgWriteRejected,       // Write refused, one cycle
  output reg         commFaultTrip,          // Trip indication shown
  output reg         faultOutput,            // Fault output signal
  output reg         coastRequest,           // Ask ramp to coast, level
  output reg         decelRequest,           // Ask ramp to decelerate, level
  output reg         restartRequest,         // Resume previous commands, pulse
  output reg         minorCommAlarm,         // Minor alarm, level
  output reg         terminalA,              // Output terminal A level
  output reg         terminalB,              // Output terminal B level
  output reg         terminalC               // Output terminal C level
);

  // Stop sequence states
  localparam [2:0] S_RUN       = 3'h0;   // Normal operation
  localparam [2:0] S_DECEL     = 3'h1;   // Mode 1 decelerating
  localparam [2:0] S_TRIP      = 3'h2;   // Stopped with trip latched
  localparam [2:0] S_SOFT_DEC  = 3'h3;   // Mode 2 decelerating
  localparam [2:0] S_SOFT_HOLD = 3'h4;   // Mode 2 stopped, awaiting recovery

  reg  [2:0]  state;                     // Current stop state
  reg  [2:0]  next_state;                // Next stop state
  reg  [13:0] errCount;                  // Consecutive receive errors
  reg  [13:0] lossCount;                 // Steps since last frame
  reg         lossArmed;                 // Timer running in network mode
  reg         lossFault;                 // Signal loss condition
  reg         netModeDly;                // Network mode, previous cycle
  wire        step;                      // 0.1 s step pulse
  wire        wrOk;                      // Write passes gate and range
  wire        retryActive;               // Retry checking applies
  wire        retryFault;                // Retry limit exceeded
  wire        lossEnabled;               // Loss detection switched on
  wire        netEnter;                  // Entering network run mode
  wire        faultCond;                 // Any fault condition present

  // Step timer restarts with every frame
  ces_step_gen #(
    .CYCLES (STEP_CYCLES),
    .CNT_W  (32)
  ) u_step (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .restart (frameRx),
    .step    (step)
  );

  // Range check per setting; 9999 accepted where it has a meaning
  assign wrOk = (extendedDisplaySelect == 14'h0000) &&
                (((cfgSelect == `CES_SEL_RETRY) &&
                  ((cfgData <= `CES_RETRY_MAX) || (cfgData == `CES_SET_DISABLE))) ||
                 ((cfgSelect == `CES_SEL_LOSS) && (cfgData <= `CES_SET_DISABLE)) ||
                 ((cfgSelect == `CES_SEL_MODE) && (cfgData <= {12'h000, `CES_MODE_MAX})));

  // Settings storage
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      retryLimitSetting <= `CES_RETRY_RESET;
      lossCheckInterval <= `CES_LOSS_RESET;
      errorStopMode     <= `CES_MODE_RESET;
      cfgWriteRejected  <= 1'b0;
    end
    else
    begin
      cfgWriteRejected <= cfgWrite && !wrOk;
      if (cfgWrite && wrOk)
      begin
        case (cfgSelect)
          `CES_SEL_RETRY: retryLimitSetting <= cfgData;
          `CES_SEL_LOSS:  lossCheckInterval <= cfgData;
          `CES_SEL_MODE:  errorStopMode     <= cfgData[1:0];
          default:        cfgWriteRejected  <= 1'b1; // Unused select code
        endcase
      end
    end
  end

  // Retry counting only under the computer-link protocol
  assign retryActive = !protocolModbus;
  assign retryFault  = retryActive && (retryLimitSetting != `CES_SET_DISABLE) &&
                       (errCount > retryLimitSetting);

  // Consecutive error counter; saturates so it can never wrap to zero
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      errCount <= 14'h0000;
    else if (!retryActive)
      errCount <= 14'h0000;
    else if (frameRxError)
    begin
      if (errCount != 14'h3fff)
        errCount <= errCount + 14'h0001;
    end
    else if (frameRx)
      errCount <= 14'h0000;
  end

  assign lossEnabled = (lossCheckInterval != `CES_SET_DISABLE);
  assign netEnter    = networkRunMode && !netModeDly;

  // Signal loss timer and condition
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      netModeDly <= 1'b0;
      lossArmed  <= 1'b0;
      lossCount  <= 14'h0000;
      lossFault  <= 1'b0;
    end
    else
    begin
      netModeDly <= networkRunMode;
      // Timer arms at first frame inside network mode
      if (!networkRunMode || !lossEnabled)
        lossArmed <= 1'b0;
      else if (frameRx)
        lossArmed <= 1'b1;
      // Count steps of silence, cleared by any frame
      if (frameRx || !lossArmed)
        lossCount <= 14'h0000;
      else if (step && (lossCount != 14'h3fff))
        lossCount <= lossCount + 14'h0001;
      // Interval-0 entry set wins over the clear by a frame in the same cycle
      if (lossEnabled && (lossCheckInterval == 14'h0000) && netEnter)
        lossFault <= 1'b1;
      else if (lossArmed && !frameRx && (lossCheckInterval != 14'h0000) &&
               (lossCount > lossCheckInterval))
        lossFault <= 1'b1;
      else if (frameRx || !lossEnabled)
        lossFault <= 1'b0;
    end
  end

  assign faultCond = retryFault || lossFault;

  // Stop sequence transitions
  always @*
  begin
    next_state = state;
    case (state)
      S_RUN:
      begin
        if (faultCond)
        begin
          case (errorStopMode)
            `CES_MODE_COAST: next_state = S_TRIP;
            `CES_MODE_DECEL: next_state = S_DECEL;
            default:         next_state = S_SOFT_DEC;
          endcase
        end
      end
      S_DECEL:
        if (decelDone)
          next_state = S_TRIP;
      S_TRIP:
        if (faultReset)
          next_state = S_RUN; // Latched until reset by operator
      S_SOFT_DEC:
      begin
        if (!faultCond)
          next_state = S_RUN;
        else if (decelDone)
          next_state = S_SOFT_HOLD;
      end
      S_SOFT_HOLD:
        if (!faultCond)
          next_state = S_RUN;
      default:
        next_state = S_RUN;
    endcase
  end

  // Returns terminal level for a function code
  function termLevel;
    input [7:0] code;
    input       alarm;
    begin
      if (code == `CES_TERM_ALARM_POS)
        termLevel = alarm;
      else if (code == `CES_TERM_ALARM_NEG)
        termLevel = !alarm;
      else
        termLevel = 1'b0; // Other functions are driven elsewhere
    end
  endfunction

  // State register and registered outputs decoded from next state
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state          <= S_RUN;
      commFaultTrip  <= 1'b0;
      faultOutput    <= 1'b0;
      coastRequest   <= 1'b0;
      decelRequest   <= 1'b0;
      restartRequest <= 1'b0;
      minorCommAlarm <= 1'b0;
      terminalA      <= 1'b0;
      terminalB      <= 1'b0;
      terminalC      <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // Mode 0 coasts and flags at once; mode 1 flags only after stop
      coastRequest  <= (next_state == S_TRIP) && (errorStopMode == `CES_MODE_COAST ||
                       state == S_TRIP ? coastRequest || state != S_TRIP : 1'b0);
      decelRequest  <= (next_state == S_DECEL) || (next_state == S_SOFT_DEC) ||
                       (next_state == S_SOFT_HOLD);
      commFaultTrip <= (next_state == S_TRIP) || (next_state == S_SOFT_HOLD);
      faultOutput   <= (next_state == S_TRIP);
      // Commands before the fault are held by the ramp; this pulse resumes them
      restartRequest <= ((state == S_SOFT_DEC) || (state == S_SOFT_HOLD)) &&
                        (next_state == S_RUN);
      // Minor alarm with the 9999 retry setting, cleared by a good frame
      if (!retryActive || retryLimitSetting != `CES_SET_DISABLE)
        minorCommAlarm <= 1'b0;
      else if (frameRxError)
        minorCommAlarm <= 1'b1;
      else if (frameRx)
        minorCommAlarm <= 1'b0;
      terminalA <= termLevel(outputTerminalSelectA, minorCommAlarm);
      terminalB <= termLevel(outputTerminalSelectB, minorCommAlarm);
      terminalC <= termLevel(outputTerminalSelectC, minorCommAlarm);
    end
  end

endmodule // ces_comm_error_supervisor

`default_nettype wire

// ===== ces_chk.sv
// Port-level checker for the communication error supervisor
`timescale 1ns/100ps
`default_nettype none
module ces_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        cfgWrite,
  input wire logic [1:0]  cfgSelect,
  input wire logic [13:0] cfgData,
  input wire logic [13:0] extendedDisplaySelect,
  input wire logic        networkRunMode,
  input wire logic        decelDone,
  input wire logic [7:0]  outputTerminalSelectA,
  input wire logic [13:0] retryLimitSetting,
  input wire logic [13:0] lossCheckInterval,
  input wire logic [1:0]  errorStopMode,
  input wire logic        cfgWriteRejected,
  input wire logic        commFaultTrip,
  input wire logic        faultOutput,
  input wire logic        coastRequest,
  input wire logic        decelRequest,
  input wire logic        restartRequest,
  input wire logic        minorCommAlarm,
  input wire logic        terminalA
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_rej;
    cfgWrite && extendedDisplaySelect != 14'h0 |=> cfgWriteRejected && $stable(retryLimitSetting);
  endproperty
  a_rej: assert property (p_rej) else $error("locked write was taken");
  property p_retry;
    cfgWrite && extendedDisplaySelect == 14'h0 && cfgSelect == 2'h0
      && (cfgData <= 14'h000a || cfgData == 14'h270f)
      |=> retryLimitSetting == $past(cfgData) && !cfgWriteRejected;
  endproperty
  a_retry: assert property (p_retry) else $error("legal retry limit lost");
  property p_badr;
    cfgWrite && cfgSelect == 2'h0 && cfgData > 14'h000a && cfgData != 14'h270f |=> cfgWriteRejected;
  endproperty
  a_badr: assert property (p_badr) else $error("bad retry limit taken");
  property p_mode;
    cfgWrite && cfgSelect == 2'h2 && cfgData > 14'h0002 |=> cfgWriteRejected && $stable(errorStopMode);
  endproperty
  a_mode: assert property (p_mode) else $error("bad stop mode taken");
  property p_coast;
    $rose(coastRequest) |-> commFaultTrip && faultOutput && errorStopMode == 2'h0;
  endproperty
  a_coast: assert property (p_coast) else $error("coast without trip");
  property p_m1;
    $rose(faultOutput) && errorStopMode == 2'h1 |-> decelDone && !decelRequest;
  endproperty
  a_m1: assert property (p_m1) else $error("fault output before stop");
  property p_m2;
    commFaultTrip && errorStopMode == 2'h2 |-> !faultOutput;
  endproperty
  a_m2: assert property (p_m2) else $error("fault output in restart mode");
  property p_rst;
    restartRequest |-> errorStopMode == 2'h2 ##1 !restartRequest;
  endproperty
  a_rst: assert property (p_rst) else $error("bad restart pulse");
  property p_alarm;
    retryLimitSetting != 14'h270f |-> ##1 !minorCommAlarm;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without disabled limit");
  property p_term;
    terminalA == ($past(outputTerminalSelectA) == 8'h62 ? $past(minorCommAlarm)
      : $past(outputTerminalSelectA) == 8'hc6 ? !$past(minorCommAlarm) : 1'b0);
  endproperty
  a_term: assert property (p_term) else $error("terminal level wrong");
  property p_zero;
    $rose(networkRunMode) && lossCheckInterval == 14'h0 && errorStopMode == 2'h0
      |-> ##[1:4] commFaultTrip;
  endproperty
  a_zero: assert property (p_zero) else $error("no trip on entry");
endmodule // ces_chk
bind ces_comm_error_supervisor ces_chk u_ces_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .cfgWrite(cfgWrite), .cfgSelect(cfgSelect),
  .cfgData(cfgData), .extendedDisplaySelect(extendedDisplaySelect),
  .networkRunMode(networkRunMode), .decelDone(decelDone),
  .outputTerminalSelectA(outputTerminalSelectA), .retryLimitSetting(retryLimitSetting),
  .lossCheckInterval(lossCheckInterval), .errorStopMode(errorStopMode),
  .cfgWriteRejected(cfgWriteRejected), .commFaultTrip(commFaultTrip),
  .faultOutput(faultOutput), .coastRequest(coastRequest), .decelRequest(decelRequest),
  .restartRequest(restartRequest), .minorCommAlarm(minorCommAlarm), .terminalA(terminalA));
`default_nettype wire

// ===== ces_host_model.sv
// Host computer model: heartbeat frames and single frames on request
`timescale 1ns/100ps
`default_nettype none
module ces_host_model #(
  parameter GAP = 6            // Cycles between heartbeats
) (
  input  wire logic clk_sys,
  input  wire logic run,       // Heartbeat enable
  output var  logic frameRx,
  output var  logic frameRxError
);
  int   n = 0;                 // Heartbeat spacing counter
  logic pend = 1'b0;           // Single frame waiting
  logic pbad = 1'b0;           // Single frame is corrupt
  initial frameRx = 1'b0;
  initial frameRxError = 1'b0;
  // Pulses change only on rising edges, one cycle long
  always @(posedge clk_sys)
  begin
    n <= (run && n < GAP) ? n + 1 : 0;
    frameRx <= (run && n == GAP) || (pend && !pbad);
    frameRxError <= pend && pbad;
    pend <= 1'b0;
  end
  // Request set mid-cycle so the edge that takes it is unambiguous
  task automatic send(input logic bad);
    @(negedge clk_sys);
    pend = 1'b1;
    pbad = bad;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule // ces_host_model
`default_nettype wire

// ===== tb_comm_error_supervisor.sv
// Self-checking bench for the communication error supervisor
`timescale 1ns/100ps
`default_nettype none
module tb_comm_error_supervisor;
  logic clk_sys, rst_n, cfgWrite, protocolModbus, networkRunMode, decelDone, faultReset;
  logic hRun, frameRx, frameRxError, cfgWriteRejected, commFaultTrip, faultOutput;
  logic coastRequest, decelRequest, restartRequest, minorCommAlarm;
  logic terminalA, terminalB, terminalC, t, f, c, a;
  logic [1:0] cfgSelect, errorStopMode, eM;
  logic [13:0] cfgData, extendedDisplaySelect, retryLimitSetting, lossCheckInterval, eR, eL;
  logic [7:0] outputTerminalSelectA, outputTerminalSelectB, outputTerminalSelectC;
  logic [34:0] q[$];     // Expected status words, oldest first
  logic [34:0] prev, dutw;
  int fail_count = 0;
  int cmp_count = 0;
  int i;
  assign dutw = {retryLimitSetting, lossCheckInterval, errorStopMode, cfgWriteRejected,
                 commFaultTrip, faultOutput, coastRequest, minorCommAlarm};
  ces_comm_error_supervisor #(.STEP_CYCLES(4)) u_ces_comm_error_supervisor (
    .clk_sys(clk_sys), .rst_n(rst_n), .cfgWrite(cfgWrite), .cfgSelect(cfgSelect),
    .cfgData(cfgData), .extendedDisplaySelect(extendedDisplaySelect),
    .protocolModbus(protocolModbus), .networkRunMode(networkRunMode), .frameRx(frameRx),
    .frameRxError(frameRxError), .decelDone(decelDone), .faultReset(faultReset),
    .outputTerminalSelectA(outputTerminalSelectA),
    .outputTerminalSelectB(outputTerminalSelectB),
    .outputTerminalSelectC(outputTerminalSelectC), .retryLimitSetting(retryLimitSetting),
    .lossCheckInterval(lossCheckInterval), .errorStopMode(errorStopMode),
    .cfgWriteRejected(cfgWriteRejected), .commFaultTrip(commFaultTrip),
    .faultOutput(faultOutput), .coastRequest(coastRequest), .decelRequest(decelRequest),
    .restartRequest(restartRequest), .minorCommAlarm(minorCommAlarm),
    .terminalA(terminalA), .terminalB(terminalB), .terminalC(terminalC));
  ces_host_model u_ces_host_model (.clk_sys(clk_sys), .run(hRun), .frameRx(frameRx),
                                   .frameRxError(frameRxError));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [34:0] ex(input logic rej);
    ex = {eR, eL, eM, rej, t, f, c, a};
  endfunction
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic waitq;
    for (int k = 0; k < 300 && q.size() > 0; k++) cyc(1);
    chk(35'(q.size()), 35'h0);
  endtask
  task automatic note;
    q.push_back(ex(1'b0));
  endtask
  task automatic pulseReset;
    faultReset <= 1'b1;
    cyc(1);
    faultReset <= 1'b0;
  endtask
  // One setting write; refused ones show a single-cycle reject
  task automatic wr(input logic [1:0] s, input logic [13:0] d);
    logic [34:0] w0;
    logic ok;
    cyc(1); // Idle edge so the strobe never drops and rises in one step
    w0 = ex(1'b0);
    ok = extendedDisplaySelect == 14'h0 && (s == 2'h0 ? (d <= 14'h000a || d == 14'h270f)
         : s == 2'h1 ? d <= 14'h270f : (s == 2'h2 && d <= 14'h0002));
    cfgSelect <= s;
    cfgData <= d;
    cfgWrite <= 1'b1;
    cyc(1);
    cfgWrite <= 1'b0;
    if (!ok)
    begin
      q.push_back(ex(1'b1));
      q.push_back(w0);
    end
    else if (s == 2'h0)
      eR = d;
    else if (s == 2'h1)
      eL = d;
    else
      eM = d[1:0];
    if (ok && ex(1'b0) !== w0) note();
    waitq();
  endtask
  // Every status change is matched against the oldest note
  always @(posedge clk_sys)
    if (!rst_n)
      prev = dutw;
    else if (dutw !== prev)
    begin
      chk(dutw, q.size() > 0 ? q.pop_front() : prev);
      prev = dutw;
    end
  initial
  begin
    #400000;
    fail_count++;
    test_done();
  end
  initial
  begin
    {rst_n, cfgWrite, protocolModbus, networkRunMode, decelDone, faultReset, hRun} = 7'h00;
    cfgSelect = 2'h0;
    cfgData = 14'h0000;
    extendedDisplaySelect = 14'h0000;
    outputTerminalSelectA = 8'h62;
    outputTerminalSelectB = 8'h00;
    outputTerminalSelectC = 8'h00;
    {eR, eL, eM, t, f, c, a} = {14'h0001, 14'h0000, 2'h0, 4'h0};
    void'($urandom(32'h71f3));
    cyc(12);
    rst_n <= 1'b1;
    cyc(1);
    chk(dutw, ex(1'b0));
    extendedDisplaySelect <= 14'($urandom_range(1, 9999));
    cyc(1);
    wr(2'h0, 14'h0005);
    extendedDisplaySelect <= 14'h0000;
    cyc(1);
    for (i = 0; i < 8; i++) wr(2'h0, 14'($urandom_range(0, 14)));
    wr(2'h0, 14'h000b);
    wr(2'h0, 14'h270f);
    wr(2'h3, 14'h0001);
    wr(2'h2, 14'h0003);
    wr(2'h1, 14'h2710);
    wr(2'h0, 14'h0001);
    u_ces_host_model.send(1'b1);
    u_ces_host_model.send(1'b0);
    u_ces_host_model.send(1'b1);
    {t, f, c} = 3'h7;
    note();
    u_ces_host_model.send(1'b1);
    waitq();
    u_ces_host_model.send(1'b0);
    {t, f, c} = 3'h0;
    note();
    pulseReset();
    waitq();
    protocolModbus <= 1'b1;
    repeat (3) u_ces_host_model.send(1'b1);
    protocolModbus <= 1'b0;
    u_ces_host_model.send(1'b0);
    wr(2'h0, 14'h270f);
    outputTerminalSelectB <= 8'hc6;
    outputTerminalSelectC <= 8'($urandom_range(0, 97));
    a = 1'b1;
    note();
    repeat (2) u_ces_host_model.send(1'b1);
    waitq();
    chk({32'h0, terminalA, terminalB, terminalC}, 35'h4);
    outputTerminalSelectA <= 8'hc6;
    cyc(3);
    chk({32'h0, terminalA, terminalB, terminalC}, 35'h0);
    a = 1'b0;
    note();
    u_ces_host_model.send(1'b0);
    waitq();
    cyc(2);
    chk({32'h0, terminalA, terminalB, terminalC}, 35'h6);
    wr(2'h0, 14'h0001);
    wr(2'h1, 14'h0002);
    wr(2'h2, 14'h0001);
    networkRunMode <= 1'b1;
    cyc(40);
    chk({34'h0, decelRequest}, 35'h0);
    hRun <= 1'b1;
    cyc(80);
    chk({34'h0, decelRequest}, 35'h0);
    hRun <= 1'b0;
    {t, f} = 2'h3;
    note();
    cyc(40);
    chk(35'(q.size()), 35'h1);
    chk({34'h0, decelRequest}, 35'h1);
    decelDone <= 1'b1;
    waitq();
    networkRunMode <= 1'b0;
    decelDone <= 1'b0;
    u_ces_host_model.send(1'b0);
    {t, f} = 2'h0;
    note();
    pulseReset();
    waitq();
    wr(2'h2, 14'h0002);
    networkRunMode <= 1'b1;
    u_ces_host_model.send(1'b0);
    cyc(30);
    chk({34'h0, decelRequest}, 35'h1);
    u_ces_host_model.send(1'b0);
    cyc(2);
    chk({33'h0, decelRequest, restartRequest}, 35'h1);
    t = 1'b1;
    note();
    decelDone <= 1'b1;
    waitq();
    t = 1'b0;
    note();
    u_ces_host_model.send(1'b0);
    cyc(2);
    chk({34'h0, restartRequest}, 35'h1);
    waitq();
    networkRunMode <= 1'b0;
    decelDone <= 1'b0;
    wr(2'h1, 14'h270f);
    networkRunMode <= 1'b1;
    u_ces_host_model.send(1'b0);
    cyc(80);
    chk({34'h0, decelRequest}, 35'h0);
    networkRunMode <= 1'b0;
    wr(2'h2, 14'h0000);
    wr(2'h1, 14'h0000);
    {t, f, c} = 3'h7;
    note();
    networkRunMode <= 1'b1;
    waitq();
    networkRunMode <= 1'b0;
    u_ces_host_model.send(1'b0);
    {t, f, c} = 3'h0;
    note();
    pulseReset();
    waitq();
    test_done();
  end
endmodule // tb_comm_error_supervisor
`default_nettype wire
